// ### bench/lcd_panel_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// glass panel: a pixel darkens only under the full drive swing
// ----------------------------------------------------------------
module lcd_panel_model
  import lcd_drive_pkg::*;
(
  input  wire logic [2*ROW_COUNT-1:0]         i_common_lines,
  input  wire logic [2*SEG_COUNT-1:0]         i_segment_lines,
  output logic      [ROW_COUNT*SEG_COUNT-1:0] o_lit
);
  // rms is not modelled; partial swings count as clear, which is
  // enough to tell an on pixel from an off one in any bias
  always_comb
  begin
    for (int k = 0; k < ROW_COUNT; k++)
    begin
      for (int s = 0; s < SEG_COUNT; s++)
      begin
        o_lit[k*SEG_COUNT+s] = {i_common_lines[2*k+:2], i_segment_lines[2*s+:2]} inside {4'hC, 4'h3};
      end
    end
  end
endmodule // lcd_panel_model

`default_nettype wire

// ### bench/tb_lcd_multiplex_drive_selector.sv
`timescale 1ns/100ps
`default_nettype none

module tb_lcd_multiplex_drive_selector;
  import lcd_drive_pkg::*;
  localparam int PH   = 8;
  localparam int LITS = ROW_COUNT*SEG_COUNT;

  logic                     ref_clk = 1'h0;
  logic                     rst = 1'h1;
  logic                     psel = 1'h0;
  logic                     penable = 1'h0;
  logic                     pwrite = 1'h0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic [2*ROW_COUNT-1:0]   common_lines;
  logic [2*SEG_COUNT-1:0]   segment_lines;
  logic                     bias_bypass;
  logic [LITS-1:0]          lit;
  logic [31:0]              ram [ROW_COUNT*WORDS_PER_ROW];
  int                       failures = 0;
  int                       check_count = 0;

  lcd_multiplex_drive_selector #(.PHASE_CYCLES_P(PH)) lcd_multiplex_drive_selector_i (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_common_lines(common_lines), .o_segment_lines(segment_lines), .o_bias_bypass(bias_bypass));
  lcd_panel_model lcd_panel_model_i (
    .i_common_lines(common_lines), .i_segment_lines(segment_lines), .o_lit(lit));

  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [LITS-1:0] seen, input logic [LITS-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      failures++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // one idle edge so a following call never reassigns psel in this time step
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic        e;
    apb(1'h1, addr, data, d, e);
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic        e;
    apb(1'h0, addr, 32'h0, d, e);
    check({e, d}, {exp_err, exp});
  endtask

  function automatic logic [31:0] ctrl(mode_type m, logic bank, logic half, logic on);
    return {27'h0, bank, m, half, on};
  endfunction

  function automatic int common_index(mode_type m, int k);
    case (m)
      MODE_STATIC: return 0;
      MODE_MUX2:   return k % 2;
      MODE_MUX3:   return (k == 3) ? 1 : k;
      default:     return k;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // sampling sits mid-phase so a slip of a cycle or two is tolerated
  task automatic run_mode(input mode_type m, input int nph, input logic bank);
    logic [LITS-1:0] exp;
    int              r;
    wr(CTRL_OFFSET, ctrl(m, bank, 1'h0, 1'h1));
    rd_check(CTRL_OFFSET, ctrl(m, bank, 1'h0, 1'h1), 1'h0);
    repeat (3) @(posedge ref_clk);
    #1;
    for (int p = 0; p < nph; p++)
    begin
      r = p + ((bank && m inside {MODE_STATIC, MODE_MUX2}) ? 2 : 0);
      for (int k = 0; k < ROW_COUNT; k++)
        for (int s = 0; s < SEG_COUNT; s++)
          exp[k*SEG_COUNT+s] = (common_index(m, k) == p) && ram[r*WORDS_PER_ROW+s/32][s%32];
      check(lit, exp);
      check(common_lines[7:6], common_lines[2*common_index(m, 3)+:2]);
      check(common_lines[5:4], common_lines[2*common_index(m, 2)+:2]);
      repeat (PH) @(posedge ref_clk);
    end
  endtask

  task automatic bias_and_blank();
    mode_type    modes [4] = '{MODE_STATIC, MODE_MUX2, MODE_MUX3, MODE_MUX4};
    logic [1:0]  c0;
    foreach (modes[i])
    begin
      wr(CTRL_OFFSET, ctrl(modes[i], 1'h0, 1'h1, 1'h1));
      repeat (3) @(posedge ref_clk);
      check(bias_bypass, modes[i] == MODE_MUX2);
    end
    wr(CTRL_OFFSET, ctrl(MODE_MUX2, 1'h0, 1'h0, 1'h1));
    repeat (3) @(posedge ref_clk);
    check(bias_bypass, 1'h0);
    wr(CTRL_OFFSET, ctrl(MODE_MUX4, 1'h0, 1'h0, 1'h1));
    repeat (3) @(posedge ref_clk);
    #1;
    c0 = common_lines[1:0];
    repeat (4*PH) @(posedge ref_clk);
    check(c0 ^ common_lines[1:0], 2'h3);
    wr(CTRL_OFFSET, ctrl(MODE_MUX4, 1'h0, 1'h0, 1'h0));
    repeat (3) @(posedge ref_clk);
    check({common_lines, segment_lines, bias_bypass}, '0);
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    check({common_lines, segment_lines, bias_bypass}, '0);
    rd_check(CTRL_OFFSET, 32'h0, 1'h0);
    wr(8'h80, 32'hFFFF_FFFF);
    rd_check(8'h80, 32'h0, 1'h1);
    for (int i = 0; i < ROW_COUNT*WORDS_PER_ROW; i++)
    begin
      ram[i] = 32'h3C5A_96E1 ^ (i * 32'h0113_3771);
      wr(RAM_OFFSET + 8'(4*i), ram[i]);
      if (i % WORDS_PER_ROW == 2)
        ram[i][31:16] = 16'h0;
    end
    rd_check(RAM_OFFSET + 8'h08, ram[2], 1'h0);
    run_mode(MODE_STATIC, 1, 1'h0);
    run_mode(MODE_MUX2, 2, 1'h0);
    run_mode(MODE_MUX3, 3, 1'h0);
    run_mode(MODE_MUX4, 4, 1'h0);
    run_mode(MODE_STATIC, 1, 1'h1);
    run_mode(MODE_MUX2, 2, 1'h1);
    bias_and_blank();
    give_verdict();
  end
endmodule // tb_lcd_multiplex_drive_selector

`default_nettype wire

// ### logic/lcd_drive_pkg.sv
`default_nettype none

package lcd_drive_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] STATUS_OFFSET   = 8'h04;
  localparam logic [7:0] RAM_OFFSET      = 8'h40;
  localparam int         RAM_WORDS       = 12;
  localparam int         WORDS_PER_ROW   = 3;
  localparam int         SEG_COUNT       = 80;
  localparam int         ROW_COUNT       = 4;
  localparam int         LAST_WORD_BITS  = 16;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int DISPLAY_ON_BIT = 0;
  localparam int HALF_BIAS_BIT  = 1;
  localparam int MODE_LSB       = 2;
  localparam int BANK_BIT       = 4;
  localparam int CTRL_WIDTH     = 5;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;

  // ----------------------------------------------------------------
  // drive modes, gray coded along static -> 1:2 -> 1:3 -> 1:4
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STATIC = 2'h0,
    MODE_MUX2   = 2'h1,
    MODE_MUX3   = 2'h3,
    MODE_MUX4   = 2'h2
  } mode_type;

  // ----------------------------------------------------------------
  // drive level codes: supply, lower tap, upper tap, lcd supply
  // with half bias the merged centre tap is coded as the lower tap
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_VSS  = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_VLCD = 2'h3;

  // ----------------------------------------------------------------
  // timing: one backplane phase lasts PHASE_TIME_NS
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PHASE_TIME_NS  = 1000000;
  localparam int PHASE_CYCLES   = (PHASE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PHASE_TIME_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_WIDTH = 20;

endpackage : lcd_drive_pkg

`default_nettype wire

// ### logic/lcd_multiplex_drive_selector.sv
// Functional notes
// R1: the four common lines follow the drive mode now selected, so a mode change changes their waveforms.
// R2: static mode drives a one-backplane panel with a single phase in each frame.
// R3: 1:2 mode drives a two-backplane panel and works with half or one-third bias.
// R4: 1:3 mode drives a three-backplane panel, stepping through three phases per frame.
// R5: 1:4 mode drives a four-backplane panel, each common line carrying its own phase.
// R6: in 1:3 mode the fourth common line copies the second exactly.
// R7: in 1:2 mode the third common line copies the first and the fourth copies the second.
// R8: in static mode all four common lines carry one identical waveform.
// R9: the 80 segment lines are driven from the display row bit of each column and the current phase.
// R10: the divider bypass switch closes only for half bias together with 1:2 mode.
// R11: drive mode and bias come from the mode configuration written by software.
// R12: 1:3 and 1:4 modes also accept half bias.
// R13: rows are shown in order per frame: row 0 static, 0-1 in 1:2, 0-2 in 1:3, 0-3 in 1:4.
// R14: with the bank switch set, row 2 replaces row 0 in static and rows 2-3 replace 0-1 in 1:2.
// R15: content is driven only while display-on is 1; otherwise every line sits at supply level.
// R16: each frame steps the active phases in order and alternates polarity on the next frame.
// R17: a zero segment bit gets the off-level for the phase, a one bit the on-level.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module lcd_multiplex_drive_selector
  import lcd_drive_pkg::*;
#(
  parameter int PHASE_CYCLES_P = lcd_drive_pkg::PHASE_CYCLES
)
(
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [7:0]                    i_paddr,
  input  wire logic [31:0]                   i_pwdata,
  output logic      [31:0]                   o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  output logic      [2*ROW_COUNT-1:0]        o_common_lines,
  output logic      [2*SEG_COUNT-1:0]        o_segment_lines,
  output logic                               o_bias_bypass
);
  import lcd_drive_pkg::*;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [CTRL_WIDTH-1:0]     ctrl_reg;
  logic [31:0]               ram_reg [RAM_WORDS];
  logic [1:0]                phase_reg;
  logic                      polarity_reg;
  logic [PRESCALE_WIDTH-1:0] prescale_reg;
  logic [31:0]               prdata_next;
  logic                      addr_hit;
  logic                      ram_hit;
  logic [3:0]                ram_index;
  logic                      access;

  assign ram_index = 4'((i_paddr - RAM_OFFSET) >> 2);
  assign ram_hit   = (i_paddr[1:0] == 2'h0) && (i_paddr >= RAM_OFFSET)
                     && (i_paddr < 8'(RAM_OFFSET + 4 * RAM_WORDS));
  assign addr_hit  = ram_hit || (i_paddr == CTRL_OFFSET) || (i_paddr == STATUS_OFFSET);
  assign access    = i_psel && i_penable;
  // one wait-free access phase: the read word was latched during setup
  assign o_pready  = 1'b1;
  assign o_pslverr = access && !addr_hit;

  always_comb
  begin
    prdata_next = 32'h0000_0000;
    if (i_paddr == CTRL_OFFSET)
    begin
      prdata_next = {27'h000_0000, ctrl_reg};
    end
    else if (i_paddr == STATUS_OFFSET)
    begin
      prdata_next = {28'h000_0000, o_bias_bypass, polarity_reg, phase_reg};
    end
    else if (ram_hit)
    begin
      prdata_next = ram_reg[ram_index];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_prdata <= 32'h0000_0000;
    end
    else if (i_psel && !i_penable && !i_pwrite)
    begin
      o_prdata <= prdata_next;
    end
  end

  // mode, bias, bank and display-on are set here by software
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (access && i_pwrite && i_paddr == CTRL_OFFSET)
    begin
      ctrl_reg <= i_pwdata[CTRL_WIDTH-1:0]; // R11
    end
  end

  // display ram: 4 rows of 80 bits, three words per row, upper half of the third word unused
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int w = 0; w < RAM_WORDS; w++)
      begin
        ram_reg[w] <= 32'h0000_0000;
      end
    end
    else if (access && i_pwrite && ram_hit)
    begin
      if (ram_index % 4'(WORDS_PER_ROW) == 4'(WORDS_PER_ROW - 1))
      begin
        ram_reg[ram_index] <= {16'h0000, i_pwdata[LAST_WORD_BITS-1:0]};
      end
      else
      begin
        ram_reg[ram_index] <= i_pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  mode_type mode;
  logic     display_on;
  logic     half_bias;
  logic     bank_sel;
  logic [1:0] last_phase;

  assign mode       = mode_type'(ctrl_reg[MODE_LSB +: 2]); // R1 R11
  assign display_on = ctrl_reg[DISPLAY_ON_BIT];
  assign half_bias  = ctrl_reg[HALF_BIAS_BIT]; // R3 R12
  assign bank_sel   = ctrl_reg[BANK_BIT];

  always_comb
  begin
    case (mode)
      MODE_STATIC: last_phase = 2'h0; // R2
      MODE_MUX2:   last_phase = 2'h1; // R3
      MODE_MUX3:   last_phase = 2'h2; // R4
      MODE_MUX4:   last_phase = 2'h3; // R5
      default:     last_phase = 2'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  logic       phase_end;
  mode_type   mode_seen_reg;

  assign phase_end = (prescale_reg == PRESCALE_WIDTH'(PHASE_CYCLES_P - 1));

  // a mode change restarts the frame on the next edge, so the phase sits beyond the new last phase for one cycle at most
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prescale_reg  <= '0;
      phase_reg     <= 2'h0;
      polarity_reg  <= 1'b0;
      mode_seen_reg <= MODE_STATIC;
    end
    else
    begin
      mode_seen_reg <= mode;
      if (mode != mode_seen_reg)
      begin
        prescale_reg <= '0;
        phase_reg    <= 2'h0;
      end
      else if (phase_end)
      begin
        prescale_reg <= '0;
        if (phase_reg >= last_phase)
        begin
          phase_reg    <= 2'h0; // R16
          polarity_reg <= !polarity_reg; // R16
        end
        else
        begin
          phase_reg <= phase_reg + 2'h1; // R13 R16
        end
      end
      else
      begin
        prescale_reg <= prescale_reg + PRESCALE_WIDTH'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // row select and levels
  // ----------------------------------------------------------------
  logic [1:0]           row_sel;
  logic [SEG_COUNT-1:0] row_bits;
  logic [1:0]           lvl_active;
  logic [1:0]           lvl_inactive;
  logic [1:0]           lvl_seg_on;
  logic [1:0]           lvl_seg_off;

  always_comb
  begin
    row_sel = phase_reg; // R13
    if (bank_sel && (mode == MODE_STATIC || mode == MODE_MUX2))
    begin
      row_sel = phase_reg + 2'h2; // R14
    end
  end

  always_comb
  begin
    row_bits = '0;
    for (int w = 0; w < WORDS_PER_ROW; w++)
    begin
      if (w == WORDS_PER_ROW - 1)
      begin
        row_bits[32*w +: LAST_WORD_BITS] = ram_reg[int'(row_sel) * WORDS_PER_ROW + w][LAST_WORD_BITS-1:0];
      end
      else
      begin
        row_bits[32*w +: 32] = ram_reg[int'(row_sel) * WORDS_PER_ROW + w];
      end
    end
  end

  // polarity flips every frame so the net voltage across each segment averages to zero
  always_comb
  begin
    lvl_active = polarity_reg ? LVL_VSS : LVL_VLCD; // R16
    lvl_seg_on = polarity_reg ? LVL_VLCD : LVL_VSS;
    if (half_bias)
    begin
      lvl_inactive = LVL_LOW; // R12
      lvl_seg_off  = lvl_active;
    end
    else
    begin
      lvl_inactive = polarity_reg ? LVL_HIGH : LVL_LOW;
      lvl_seg_off  = polarity_reg ? LVL_LOW : LVL_HIGH;
    end
    if (mode == MODE_STATIC)
    begin
      lvl_seg_off = lvl_active; // R2
    end
  end

  // ----------------------------------------------------------------
  // output drivers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ROW_COUNT; g++)
    begin : gen_common
      logic [1:0] src;
      always_comb
      begin
        case (mode)
          MODE_STATIC: src = 2'h0; // R8
          MODE_MUX2:   src = 2'(g % 2); // R7
          MODE_MUX3:   src = (g == 3) ? 2'h1 : 2'(g); // R6
          MODE_MUX4:   src = 2'(g); // R5
          default:     src = 2'(g);
        endcase
      end
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          o_common_lines[2*g +: 2] <= LVL_VSS;
        end
        else if (!display_on)
        begin
          o_common_lines[2*g +: 2] <= LVL_VSS; // R15
        end
        else
        begin
          o_common_lines[2*g +: 2] <= (src == phase_reg) ? lvl_active : lvl_inactive; // R1
        end
      end
    end

    for (g = 0; g < SEG_COUNT; g++)
    begin : gen_segment
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          o_segment_lines[2*g +: 2] <= LVL_VSS;
        end
        else if (!display_on)
        begin
          o_segment_lines[2*g +: 2] <= LVL_VSS; // R15
        end
        else
        begin
          o_segment_lines[2*g +: 2] <= row_bits[g] ? lvl_seg_on : lvl_seg_off; // R9 R17
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_bias_bypass <= 1'b0;
    end
    else
    begin
      o_bias_bypass <= half_bias && (mode == MODE_MUX2); // R10
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  mux3_mirror_a: assert property ($past(display_on) && $past(mode) == MODE_MUX3 |-> // R6
    o_common_lines[7:6] == o_common_lines[3:2]) else $error("fourth common differs from second in 1:3");
  mux2_pair_a: assert property ($past(mode) == MODE_MUX2 |-> // R7
    o_common_lines[5:4] == o_common_lines[1:0] && o_common_lines[7:6] == o_common_lines[3:2])
    else $error("common pairs differ in 1:2");
  static_same_a: assert property ($past(mode) == MODE_STATIC |-> // R8
    o_common_lines == {4{o_common_lines[1:0]}}) else $error("common lines differ in static");
  // only one line may sit at a full-swing level in any 1:4 phase; the other three rest on a tap
  mux4_distinct_a: assert property ($past(display_on) && $past(mode) == MODE_MUX4 |-> // R5
    $onehot({~^o_common_lines[7:6], ~^o_common_lines[5:4], ~^o_common_lines[3:2], ~^o_common_lines[1:0]}))
    else $error("not exactly one common line active in 1:4");
  bias_switch_a: assert property (##1 o_bias_bypass == ($past(half_bias) && $past(mode) == MODE_MUX2)) // R10
    else $error("bias bypass switch wrong");
  blank_off_a: assert property (!display_on |=> o_common_lines == '0 && o_segment_lines == '0) // R15
    else $error("panel driven while display is off");
  phase_range_a: assert property (mode == $past(mode) |-> phase_reg <= last_phase) // R13
    else $error("phase beyond last phase");
  frame_flip_a: assert property (phase_end && phase_reg >= last_phase && mode == mode_seen_reg // R16
    |=> polarity_reg != $past(polarity_reg) && phase_reg == 2'h0) else $error("frame wrap missed");
  seg_level_a: assert property (display_on && mode == MODE_STATIC && row_bits[0] |=> // R9 R17
    o_segment_lines[1:0] != o_common_lines[1:0]) else $error("static on segment equals backplane");
  row_bank_a: assert property (bank_sel && mode == MODE_STATIC && mode == mode_seen_reg |-> row_sel == 2'h2) // R14
    else $error("bank switch ignored");

  mux4_frame_c: cover property (mode == MODE_MUX4 && display_on && phase_reg == 2'h3 && phase_end);
  half_mux2_c:  cover property (o_bias_bypass && display_on);
  bank_c:       cover property (bank_sel && mode == MODE_MUX2 && phase_reg == 2'h1);
  mode_chg_c:   cover property (display_on && mode != mode_seen_reg);

endmodule // lcd_multiplex_drive_selector

`default_nettype wire
